// >>> pbp_pkg.sv
/*
 package for the processor bus slave port: transfer sizes, widths,
 states and the struct carriers shared by the port and the system bus model.
 assumes one clock, i_mclk, driven from the processor bus clock.
*/
package pbp_pkg;
    // ------------------------------------------------------------
    // sizes and widths
    // ------------------------------------------------------------
    localparam logic [1:0] PBP_TSZ_WORD = 2'h0;
    localparam logic [1:0] PBP_TSZ_BYTE = 2'h1;
    localparam logic [1:0] PBP_TSZ_HALF = 2'h2;
    localparam logic [1:0] PBP_WID_8    = 2'h0;
    localparam logic [1:0] PBP_WID_16   = 2'h1;
    localparam logic [1:0] PBP_WID_32   = 2'h2;
    localparam logic [1:0] PBP_PAR_1    = 2'h0;
    localparam logic [1:0] PBP_PAR_2    = 2'h1;
    localparam logic [1:0] PBP_PAR_4    = 2'h2;
    localparam int         PBP_ADDR_W   = 18;
    localparam int         PBP_LANES    = 4;
    localparam logic [7:0] PBP_WAIT_MAX = 8'hff;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        PBP_IDLE = 2'b00,
        PBP_SYS  = 2'b01,
        PBP_END  = 2'b10
    } pbp_state_t;

    typedef struct packed {
        logic                  valid;
        logic                  rd;
        logic [PBP_ADDR_W-1:0] addr;
        logic [31:0]           wdata;
        logic [3:0]            be;
    } pbp_sys_req_t;

    typedef struct packed {
        logic        done;
        logic        err;
        logic        retry;
        logic [31:0] rdata;
    } pbp_sys_rsp_t;

    typedef struct packed {
        pbp_state_t   state;
        pbp_sys_req_t req;
        logic [31:0]  rdata;
        logic [3:0]   par;
        logic [3:0]   lane_oe;
        logic         ack_n;
        logic         tea_n;
        logic         rtry;
        logic         perr;
        logic [7:0]   wait_cnt;
    } pbp_st_t;
endpackage : pbp_pkg

// >>> pbp_lanes.sv
/*
 lane helper: byte enables from size, address and port width, and the
 per-lane parity bits. purely combinational; the caller registers.
*/
`timescale 1ns/100ps
module pbp_lanes (
    // request
    input  wire logic [1:0]  i_tsize,
    input  wire logic [1:0]  i_addr_lo,
    input  wire logic [1:0]  i_width,
    input  wire logic [31:0] i_data,
    // result
    output logic      [3:0]  o_be,
    output logic      [3:0]  o_par
);
    logic [3:0] be_raw;
    logic [3:0] width_mask;

    always_comb begin
        case (i_tsize)
            pbp_pkg::PBP_TSZ_BYTE: be_raw = 4'h1 << i_addr_lo;
            pbp_pkg::PBP_TSZ_HALF: be_raw = i_addr_lo[1] ? 4'hc : 4'h3;
            default:               be_raw = 4'hf;
        endcase
        case (i_width)
            pbp_pkg::PBP_WID_8:  width_mask = 4'h1;
            pbp_pkg::PBP_WID_16: width_mask = 4'h3;
            default:             width_mask = 4'hf;
        endcase
    end

    // narrow ports enable all low lanes of their width, whatever the size and address
    assign o_be = (i_width == pbp_pkg::PBP_WID_32) ? be_raw : width_mask;

    // parity per lane, lane 0 is the most significant byte, big-endian bits
    genvar g;
    generate
        for (g = 0; g < pbp_pkg::PBP_LANES; g++) begin : g_par
            assign o_par[g] = ^i_data[31-8*g -: 8];
        end
    endgenerate
endmodule : pbp_lanes

// >>> pbp_port.sv
/*
 processor bus slave port: takes host cycles on the port bus clock and
 forwards them to the internal system bus, returning ack, error or retry.
 assumes i_mclk is the port bus clock and also clocks the system bus.
*/
`timescale 1ns/100ps
module pbp_port (
    // clock and reset
    input  wire logic                           i_mclk,
    input  wire logic                           i_rst_n,
    // configuration
    input  wire logic                           i_port_en,
    input  wire logic [1:0]                     i_width,
    input  wire logic [1:0]                     i_par_width,
    // host bus
    input  wire logic                           i_strobe_n,
    input  wire logic                           i_read_write_dir,
    input  wire logic [1:0]                     i_transfer_size,
    input  wire logic                           i_burst_indicator_n,
    input  wire logic [pbp_pkg::PBP_ADDR_W-1:0] i_addr,
    input  wire logic [31:0]                    i_data,
    output logic      [31:0]                    o_data,
    output logic      [3:0]                     o_data_oe,
    input  wire logic [3:0]                     i_lane_parity_bus,
    output logic      [3:0]                     o_lane_parity_bus,
    output logic      [3:0]                     o_lane_parity_oe,
    output logic                                o_transfer_ack_n,
    output logic                                o_transfer_error_ack_n,
    output logic                                o_retry_request,
    output logic                                o_ctl_oe,
    output logic                                o_parity_err,
    // system bus
    output pbp_pkg::pbp_sys_req_t               o_sys_req,
    input  wire pbp_pkg::pbp_sys_rsp_t          i_sys_rsp,
    output logic                                o_sys_clk_sel
);
    pbp_pkg::pbp_st_t st_reg;
    pbp_pkg::pbp_st_t st_next;
    logic [3:0]       be_req;
    logic [3:0]       par_wr;
    logic [3:0]       par_rd;
    logic [3:0]       par_mask;
    logic             start;

    // ------------------------------------------------------------
    // lanes and parity
    // ------------------------------------------------------------
    pbp_lanes u_lanes_wr (
        .i_tsize   (i_transfer_size),
        .i_addr_lo (i_addr[1:0]),
        .i_width   (i_width),
        .i_data    (i_data),
        .o_be      (be_req),
        .o_par     (par_wr)
    );

    pbp_lanes u_lanes_rd (
        .i_tsize   (i_transfer_size),
        .i_addr_lo (i_addr[1:0]),
        .i_width   (i_width),
        .i_data    (i_sys_rsp.rdata),
        .o_be      (),
        .o_par     (par_rd)
    );

    always_comb begin
        case (i_par_width)
            pbp_pkg::PBP_PAR_1: par_mask = 4'h1;
            pbp_pkg::PBP_PAR_2: par_mask = 4'h3;
            default:            par_mask = 4'hf;
        endcase
    end

    assign start = i_port_en && !i_strobe_n;

    // ------------------------------------------------------------
    // cycle sequencer
    // ------------------------------------------------------------
    always_comb begin
        st_next       = st_reg;
        st_next.ack_n = 1'b1;
        st_next.tea_n = 1'b1;
        st_next.rtry  = 1'b0;
        st_next.perr  = 1'b0;
        case (st_reg.state)
            pbp_pkg::PBP_IDLE: begin
                st_next.lane_oe = 4'h0;
                if (start) begin
                    st_next.req.valid = 1'b1;
                    st_next.req.rd    = i_read_write_dir;
                    st_next.req.addr  = i_addr;
                    st_next.req.wdata = i_data;
                    st_next.req.be    = be_req;
                    st_next.wait_cnt  = 8'h00;
                    st_next.perr      = !i_read_write_dir
                        && |((par_wr ^ i_lane_parity_bus) & par_mask & be_req);
                    st_next.state     = pbp_pkg::PBP_SYS;
                end
            end
            pbp_pkg::PBP_SYS: begin
                st_next.wait_cnt = st_reg.wait_cnt + 8'h01;
                if (i_sys_rsp.done) begin
                    st_next.req.valid = 1'b0;
                    st_next.state     = pbp_pkg::PBP_END;
                    // one terminator only, error outranks retry
                    if (i_sys_rsp.err) begin
                        st_next.tea_n = 1'b0;
                    end else if (i_sys_rsp.retry) begin
                        st_next.rtry = 1'b1;
                    end else begin
                        st_next.ack_n = 1'b0;
                        if (st_reg.req.rd) begin
                            st_next.rdata   = i_sys_rsp.rdata;
                            st_next.par     = par_rd & par_mask;
                            st_next.lane_oe = st_reg.req.be;
                        end
                    end
                end else if (st_reg.wait_cnt == pbp_pkg::PBP_WAIT_MAX) begin
                    // a hung system bus must not hang the host forever
                    st_next.req.valid = 1'b0;
                    st_next.tea_n     = 1'b0;
                    st_next.state     = pbp_pkg::PBP_END;
                end
            end
            pbp_pkg::PBP_END: begin
                // wait for strobe release so one cycle gets one answer
                st_next.lane_oe = 4'h0;
                if (i_strobe_n) begin
                    st_next.state = pbp_pkg::PBP_IDLE;
                end
            end
            default: st_next.state = pbp_pkg::PBP_IDLE;
        endcase
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            st_reg         <= '0;
            st_reg.ack_n   <= 1'b1;
            st_reg.tea_n   <= 1'b1;
            st_reg.state   <= pbp_pkg::PBP_IDLE;
        end else begin
            st_reg <= st_next;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign o_sys_req              = st_reg.req;
    assign o_sys_clk_sel          = i_port_en;
    assign o_data                 = st_reg.rdata;
    assign o_data_oe              = st_reg.lane_oe;
    assign o_lane_parity_bus      = st_reg.par;
    assign o_lane_parity_oe       = st_reg.lane_oe & par_mask;
    assign o_transfer_ack_n       = st_reg.ack_n;
    assign o_transfer_error_ack_n = st_reg.tea_n;
    assign o_retry_request        = st_reg.rtry;
    assign o_ctl_oe               = i_port_en;
    assign o_parity_err           = st_reg.perr;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence s_sys_done;
        st_reg.state == pbp_pkg::PBP_SYS && i_sys_rsp.done;
    endsequence

    one_term_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        $onehot0({!o_transfer_ack_n, !o_transfer_error_ack_n, o_retry_request}))
        else $error("more than one terminator");
    err_tea_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        s_sys_done and i_sys_rsp.err |=> !o_transfer_error_ack_n)
        else $error("error not reported");
    retry_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        s_sys_done and !i_sys_rsp.err && i_sys_rsp.retry |=> o_retry_request)
        else $error("retry not raised");
    ack_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        s_sys_done and !i_sys_rsp.err && !i_sys_rsp.retry |=> !o_transfer_ack_n)
        else $error("ack missing");
    rd_drive_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        |o_data_oe |-> !o_transfer_ack_n && st_reg.req.rd)
        else $error("data driven outside read ack");
    lane_mask_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        i_width == pbp_pkg::PBP_WID_8 && start && st_reg.state == pbp_pkg::PBP_IDLE
        |=> st_reg.req.be == 4'h1)
        else $error("lane outside port width");
    par_lane_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (o_lane_parity_oe & ~par_mask) == 4'h0)
        else $error("parity lane outside width");
    clk_sel_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        o_sys_clk_sel == i_port_en && o_ctl_oe == i_port_en)
        else $error("clock select or pin ownership wrong");
    idle_quiet_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        !i_port_en && st_reg.state == pbp_pkg::PBP_IDLE |=> !o_sys_req.valid)
        else $error("disabled port started a cycle");
endmodule : pbp_port

// >>> pbp_sys_model.sv
/*
 system bus model behind the processor bus slave port.
 assumes the port's request struct; answers i_delay+1 cycles after the request.
*/
`timescale 1ns/100ps
module pbp_sys_model (
    // clock and reset
    input  wire logic                  i_mclk,
    input  wire logic                  i_rst_n,
    // behaviour: 0 ok, 1 error, 2 retry, 3 never answer
    input  wire logic [7:0]            i_delay,
    input  wire logic [1:0]            i_kind,
    input  wire logic [31:0]           i_rdata,
    // system bus
    input  wire pbp_pkg::pbp_sys_req_t i_req,
    output pbp_pkg::pbp_sys_rsp_t      o_rsp
);
    // ----------------------------------------
    // response timing
    // ----------------------------------------
    logic [7:0] cnt_reg;
    logic       busy_reg;
    logic       done_reg;
    // shares the port bus clock, as the port selects it
    always_ff @(posedge i_mclk) begin
        done_reg <= 1'b0;
        if (!i_rst_n) begin
            cnt_reg  <= 8'h00;
            busy_reg <= 1'b0;
        end else if (i_req.valid && !busy_reg && i_kind != 2'h3) begin
            done_reg <= (cnt_reg == i_delay);
            busy_reg <= (cnt_reg == i_delay);
            cnt_reg  <= cnt_reg + 8'h01;
        end else if (!i_req.valid) begin
            busy_reg <= 1'b0;
            cnt_reg  <= 8'h00;
        end
    end
    // data outside done is inverted so a stale sample never matches
    assign o_rsp = '{done_reg, done_reg && i_kind == 2'h1,
                     done_reg && i_kind == 2'h2,
                     done_reg ? i_rdata : ~i_rdata};
endmodule : pbp_sys_model

// >>> tb.sv
/*
 bench for the processor bus slave port: host cycles against a bus model.
 assumes a 100 MHz clock and synchronous active-low reset.
*/
`timescale 1ns/100ps
module tb;
    // ----------------------------------------
    // signals
    // ----------------------------------------
    localparam logic [31:0] RDAT = 32'ha5c3_0f96;
    logic i_mclk = 1'b0, i_rst_n = 1'b0, i_port_en = 1'b1, stb_n = 1'b1, rw = 1'b0;
    logic [1:0] wid = pbp_pkg::PBP_WID_32, pw = pbp_pkg::PBP_PAR_4, tsz = 2'h0, kind = 2'h0;
    logic [17:0] addr = 18'h0;
    logic [31:0] wd = 32'h0, o_data;
    logic [3:0] par = 4'h0, o_data_oe, o_par, poe;
    logic [7:0] dly = 8'h00;
    logic ack_n, tea_n, rtry, ctl_oe, perr, clk_sel;
    pbp_pkg::pbp_sys_req_t sreq;
    pbp_pkg::pbp_sys_rsp_t srsp;
    int error_cnt = 0, n_checks = 0;
    always #5 i_mclk = ~i_mclk;
    pbp_port DUT (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_port_en(i_port_en),
        .i_width(wid), .i_par_width(pw), .i_strobe_n(stb_n),
        .i_read_write_dir(rw), .i_transfer_size(tsz), .i_burst_indicator_n(1'b1),
        .i_addr(addr), .i_data(wd), .o_data(o_data), .o_data_oe(o_data_oe),
        .i_lane_parity_bus(par), .o_lane_parity_bus(o_par), .o_lane_parity_oe(poe),
        .o_transfer_ack_n(ack_n), .o_transfer_error_ack_n(tea_n),
        .o_retry_request(rtry), .o_ctl_oe(ctl_oe), .o_parity_err(perr),
        .o_sys_req(sreq), .i_sys_rsp(srsp), .o_sys_clk_sel(clk_sel));
    pbp_sys_model u_sys (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_delay(dly),
        .i_kind(kind), .i_rdata(RDAT), .i_req(sreq), .o_rsp(srsp));
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [3:0] par4(input logic [31:0] d);
        return {^d[7:0], ^d[15:8], ^d[23:16], ^d[31:24]};
    endfunction : par4
    function automatic logic [31:0] lmask(input logic [3:0] b);
        return {{8{b[0]}}, {8{b[1]}}, {8{b[2]}}, {8{b[3]}}};
    endfunction : lmask
    // parity lanes in use for each parity width setting
    function automatic logic [3:0] pmask(input logic [1:0] p);
        return (p == pbp_pkg::PBP_PAR_1) ? 4'h1 : (p == pbp_pkg::PBP_PAR_2) ? 4'h3 : 4'hf;
    endfunction : pmask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic final_report();
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : final_report
    // one host cycle; the bus model answers as k and d8 say
    task automatic xfer(input logic r, input logic [1:0] sz, input logic [17:0] a,
        input logic [31:0] w, input logic bad, input logic [1:0] k, input logic [7:0] d8,
        input logic [3:0] eb);
        logic [31:0] d, sw;
        logic [3:0] be, oe, pb, po;
        logic pe, fin;
        int n, t, et, lat;
        {d, sw, be, oe, pb, po, pe, fin, n, t, lat} = '0;
        et = (k == 2'h2) ? 2 : (k != 2'h0) ? 1 : 0;
        @(posedge i_mclk);
        {stb_n, rw, tsz, addr, wd, par, dly, kind} <= {1'b0, r, sz, a, w,
            bad ? ~par4(w) : par4(w), d8, k};
        for (int i = 0; i < 400 && !fin; i++) begin
            @(posedge i_mclk);
            #1;
            pe |= (perr === 1'b1);
            if (sreq.valid === 1'b1) {be, sw} = {sreq.be, sreq.wdata};
            n = (ack_n === 1'b0) + (tea_n === 1'b0) + (rtry === 1'b1);
            if (n != 0) begin
                fin = 1'b1;
                lat = i;
                t = (ack_n === 1'b0) ? 0 : (tea_n === 1'b0) ? 1 : 2;
                {d, oe, pb, po} = {o_data, o_data_oe, o_par, poe};
            end
        end
        if (!fin) begin
            error_cnt++;
            final_report();
        end else begin
            chk("terminator", et, t);
            chk("terminator count", 1, n);
            // take, model delay, answer; a silent system bus runs out the wait counter
            chk("latency", (k == 2'h3) ? int'(pbp_pkg::PBP_WAIT_MAX) + 1 : 2 + d8, lat);
            chk("byte enables", eb, be);
            chk("parity flag", bad, pe);
            if (!r) chk("write data", w & lmask(eb), sw & lmask(eb));
            if (r && et == 0) chk("read data", RDAT & lmask(eb), d & lmask(eb));
            chk("data enable", (r && et == 0) ? eb : 4'h0, oe);
            chk("parity enable", (r && et == 0) ? eb & pmask(pw) : 4'h0, po);
            if (r && et == 0) chk("read parity", par4(RDAT) & eb & pmask(pw), pb & eb);
            @(posedge i_mclk);
            stb_n <= 1'b1;
            repeat (3) @(posedge i_mclk);
        end
    endtask : xfer
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_sizes();
        logic [1:0] sz;
        for (int r = 0; r < 2; r++) begin
            for (int i = 0; i < 7; i++) begin
                sz = i < 4 ? pbp_pkg::PBP_TSZ_BYTE : i < 6 ? pbp_pkg::PBP_TSZ_HALF : 2'h0;
                xfer(r[0], sz, 18'(i < 4 ? i : i < 6 ? (i - 4) * 2 : 0),
                    32'h1357_9bdf + i, 1'b0, 2'h0, 8'h00,
                    4'(i < 4 ? 1 << i : i < 6 ? 3 << ((i - 4) * 2) : 15));
            end
        end
    endtask : t_sizes
    task automatic t_widths();
        @(posedge i_mclk);
        wid <= pbp_pkg::PBP_WID_8;
        xfer(1'b1, 2'h0, 18'h0, 32'h0, 1'b0, 2'h0, 8'h02, 4'h1);
        @(posedge i_mclk);
        wid <= pbp_pkg::PBP_WID_16;
        xfer(1'b1, 2'h0, 18'h0, 32'h0, 1'b0, 2'h0, 8'h02, 4'h3);
        @(posedge i_mclk);
        {wid, pw} <= {pbp_pkg::PBP_WID_32, pbp_pkg::PBP_PAR_2};
        xfer(1'b1, 2'h0, 18'h0, 32'h0, 1'b0, 2'h0, 8'h01, 4'hf);
        @(posedge i_mclk);
        pw <= pbp_pkg::PBP_PAR_1;
        xfer(1'b0, 2'h0, 18'h4, 32'h8421_7bde, 1'b1, 2'h0, 8'h00, 4'hf);
        @(posedge i_mclk);
        pw <= pbp_pkg::PBP_PAR_4;
    endtask : t_widths
    task automatic t_errors();
        xfer(1'b1, 2'h0, 18'h100, 32'h0, 1'b0, 2'h1, 8'h14, 4'hf);
        xfer(1'b0, 2'h0, 18'h104, 32'h2468_ace0, 1'b0, 2'h2, 8'h05, 4'hf);
        xfer(1'b1, 2'h0, 18'h108, 32'h0, 1'b0, 2'h3, 8'h00, 4'hf);
        xfer(1'b0, 2'h0, 18'h10c, 32'h0f1e_2d3c, 1'b1, 2'h0, 8'h01, 4'hf);
    endtask : t_errors
    task automatic t_disabled();
        logic seen;
        seen = 1'b0;
        @(posedge i_mclk);
        {i_port_en, stb_n} <= 2'b00;
        repeat (10) begin
            @(posedge i_mclk);
            #1;
            seen |= (sreq.valid === 1'b1);
        end
        chk("disabled pins", 3'h0, {seen, ctl_oe, clk_sel});
        @(posedge i_mclk);
        {i_port_en, stb_n} <= 2'b11;
        repeat (3) @(posedge i_mclk);
        #1;
        chk("enabled pins", 2'h3, {ctl_oe, clk_sel});
    endtask : t_disabled
    initial begin
        repeat (20) @(posedge i_mclk);
        #1;
        chk("idle outputs", 8'hc0, {ack_n, tea_n, rtry, sreq.valid, o_data_oe});
        @(posedge i_mclk);
        i_rst_n <= 1'b1;
        t_sizes();
        t_widths();
        t_errors();
        t_disabled();
        final_report();
    end
endmodule : tb
